/* File: include/scm_pkg.sv */
// Shared constants and types for the SIMD channel mask and result block
package scm_pkg;
  // Channel and datapath geometry
  localparam int CHANNELS = 32;
  localparam int CH_W = 5;
  localparam int CNT_W = 6;
  localparam int QUAD = 4;
  localparam int DATA_W = 32;
  localparam int EXEC_W = 33; // Holds both signed and unsigned dwords
  localparam int IP_W = 12;
  localparam int DREG_W = 3; // Destination register number
  localparam int DST_IDX_W = 6; // Eight registers of eight dwords
  localparam logic [CNT_W-1:0] MAX_COUNT = 6'h20;
  localparam logic [CNT_W-1:0] ONE_COUNT = 6'h01;

  // Avalon byte address layout: region in [11:8], word in [7:2]
  localparam int ADDR_W = 12;
  localparam int REGION_LSB = 8;
  localparam int WORD_LSB = 2;
  localparam logic [3:0] R_CSR = 4'h0;
  localparam logic [3:0] R_SRC = 4'h1;
  localparam logic [3:0] R_DST = 4'h2;
  localparam logic [3:0] R_ACC = 4'h3;
  localparam logic [3:0] R_PER_CHANNEL_INSTRUCTION_POINTER = 4'h4;
  localparam logic [5:0] W_CTRL = 6'h00; // control_register_zero
  localparam logic [5:0] W_STATUS = 6'h01;
  localparam logic [5:0] W_FLAG_A = 6'h02; // flag_subregister_a
  localparam logic [5:0] W_FLAG_B = 6'h03;

  // Control register zero fields
  localparam int CTRL_W = 4;
  localparam int CTRL_ACC_DIS = 0;
  localparam int CTRL_SPF = 1;
  localparam int CTRL_FLUSH = 2;
  localparam int CTRL_EXC_EN = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_ENDED = 1;
  localparam int ST_EXC = 2;

  // Single precision constants
  localparam int F_SIGN = 31;
  localparam logic [7:0] F_EXP_ONES = 8'hFF;
  localparam logic [7:0] F_EXP_BIAS = 8'h7F;
  localparam logic [DATA_W-1:0] F_ONE = 32'h3F80_0000;
  localparam logic [30:0] F_MAX_MAG = 31'h7F7F_FFFF;
  // Integer saturation bounds in the execution width
  localparam logic [EXEC_W-1:0] UD_MAX = 33'h0_FFFF_FFFF;
  localparam logic [EXEC_W-1:0] D_MAX = 33'h0_7FFF_FFFF;
  localparam logic [EXEC_W-1:0] D_MIN = 33'h1_8000_0000;
  localparam logic [EXEC_W-1:0] UW_MAX = 33'h0_0000_FFFF;
  localparam logic [EXEC_W-1:0] W_MAX = 33'h0_0000_7FFF;
  localparam logic [EXEC_W-1:0] W_MIN = 33'h1_FFFF_8000;

  typedef enum logic [2:0] {TY_UD, TY_D, TY_UW, TY_W, TY_F} scm_type_t;
  typedef enum logic [1:0] {MOD_NONE, MOD_NEG, MOD_ABS, MOD_NEG_ABS}
    scm_mod_t;
  typedef enum logic [2:0] {CM_NONE, CM_ZERO, CM_NOT_ZERO, CM_GREATER,
    CM_LESS} scm_cond_t;
  typedef enum logic [1:0] {PC_NONE, PC_PER_CHANNEL, PC_ANY_QUAD,
    PC_ALL_QUAD} scm_pred_t;
  typedef enum logic {ST_IDLE, ST_RUN} scm_state_t;

  // One decoded instruction from the decoder and dispatcher
  typedef struct packed {
    logic [CNT_W-1:0] channelCount;
    logic [CHANNELS-1:0] executionChannelMask;
    logic ignoreMasks;
    scm_pred_t predicateCombineSelect;
    logic predicateInvert;
    logic flagSel;
    logic quadAlignedAccess;
    logic [QUAD-1:0] destChannelWriteEnable;
    logic [QUAD-1:0][1:0] swizzle;
    scm_type_t srcType;
    scm_type_t dstType;
    scm_mod_t srcMod;
    logic saturate;
    scm_cond_t conditionModifier;
    logic accumulatorWriteSelect;
    logic [DREG_W-1:0] dstReg;
    logic isSend;
    logic threadEndFlag;
    logic [IP_W-1:0] ip;
  } scm_inst_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    scm_type_t srcType;
    scm_type_t dstType;
    scm_mod_t srcMod;
    logic saturate;
    logic flushMode;
    scm_cond_t condMod;
  } scm_elem_in_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic condBit;
  } scm_elem_out_t;
endpackage

/* File: src/scm_elem_unit.sv */
`timescale 1ns/1ps
// One element: convert, modify, saturate and test against zero
module scm_elem_unit import scm_pkg::*; (
  input scm_elem_in_t elemIn,
  output scm_elem_out_t elemOut
);
  logic srcIsF; // Execution type is float
  logic [DATA_W-1:0] fVal; // Float after flush and modifier
  logic [DATA_W-1:0] fRes; // Float after saturation
  logic [EXEC_W-1:0] iVal; // Integer in the execution width
  logic [EXEC_W-1:0] iMod; // Integer after modifier
  logic [EXEC_W-1:0] iRes; // Integer in destination range
  logic fIsNan;
  logic fIsZero;
  logic iNeg;

  // Whole element datapath; the operation itself is a move
  always_comb begin
    srcIsF = (elemIn.srcType == TY_F);
    fVal = elemIn.data;
    // Flush mode cleans inputs so no inf, denorm or NaN reaches the output
    if (elemIn.flushMode && fVal[30:23] == F_EXP_ONES) begin
      fVal = (fVal[22:0] == '0) ? {fVal[F_SIGN], F_MAX_MAG} : '0;
    end else if (elemIn.flushMode && fVal[30:23] == '0) begin
      fVal = {fVal[F_SIGN], 31'h0000_0000};
    end
    // Modifier applies after conversion to the execution type
    case (elemIn.srcMod)
      MOD_NEG: fVal[F_SIGN] = ~fVal[F_SIGN];
      MOD_ABS: fVal[F_SIGN] = 1'b0;
      MOD_NEG_ABS: fVal[F_SIGN] = 1'b1;
      default: fVal[F_SIGN] = fVal[F_SIGN];
    endcase
    fIsNan = (fVal[30:23] == F_EXP_ONES) && (fVal[22:0] != '0);
    fRes = fVal;
    // Float saturation: negatives and NaN to zero, above one to one
    if (elemIn.saturate && (fIsNan || fVal[F_SIGN])) begin
      fRes = '0;
    end else if (elemIn.saturate && fVal[30:23] >= F_EXP_BIAS) begin
      fRes = F_ONE;
    end
    fIsZero = (fRes[30:0] == '0);
    // Source to execution type: widen with or without sign
    case (elemIn.srcType)
      TY_D: iVal = {elemIn.data[31], elemIn.data};
      TY_UW: iVal = {17'h0_0000, elemIn.data[15:0]};
      TY_W: iVal = {{17{elemIn.data[15]}}, elemIn.data[15:0]};
      default: iVal = {1'b0, elemIn.data};
    endcase
    iNeg = iVal[EXEC_W-1];
    case (elemIn.srcMod)
      MOD_NEG: iMod = -iVal;
      MOD_ABS: iMod = iNeg ? -iVal : iVal;
      MOD_NEG_ABS: iMod = iNeg ? iVal : -iVal;
      default: iMod = iVal;
    endcase
    iRes = iMod;
    // Execution to destination type: clamp when saturating, else wrap
    case (elemIn.dstType)
      TY_UD: begin
        if (elemIn.saturate && iMod[EXEC_W-1]) iRes = '0;
        else iRes = {1'b0, iMod[31:0]};
      end
      TY_D: begin
        if (elemIn.saturate && $signed(iMod) > $signed(D_MAX)) iRes = D_MAX;
        else if (elemIn.saturate && $signed(iMod) < $signed(D_MIN))
          iRes = D_MIN;
        else iRes = {iMod[31], iMod[31:0]};
      end
      TY_UW: begin
        if (elemIn.saturate && iMod[EXEC_W-1]) iRes = '0;
        else if (elemIn.saturate && iMod > UW_MAX) iRes = UW_MAX;
        else iRes = {17'h0_0000, iMod[15:0]};
      end
      TY_W: begin
        if (elemIn.saturate && $signed(iMod) > $signed(W_MAX)) iRes = W_MAX;
        else if (elemIn.saturate && $signed(iMod) < $signed(W_MIN))
          iRes = W_MIN;
        else iRes = {{17{iMod[15]}}, iMod[15:0]};
      end
      default: iRes = iMod; // Float destination keeps integer bits
    endcase
    elemOut.result = srcIsF ? fRes : iRes[DATA_W-1:0];
    // Condition bit tests the final value against zero
    case (elemIn.condMod)
      CM_ZERO: elemOut.condBit = srcIsF ? fIsZero : (iRes == '0);
      CM_NOT_ZERO: elemOut.condBit = srcIsF ? !fIsZero : (iRes != '0);
      CM_GREATER: elemOut.condBit = srcIsF ? (!fRes[F_SIGN] && !fIsZero)
        : (!iRes[EXEC_W-1] && iRes != '0);
      CM_LESS: elemOut.condBit = srcIsF ? (fRes[F_SIGN] && !fIsZero)
        : iRes[EXEC_W-1];
      default: elemOut.condBit = 1'b0;
    endcase
  end
endmodule

/* File: src/scm_channel_exec.sv */
`timescale 1ns/1ps
// How it works
// - Channel runs only when all five enables agree
// - Ignore-masks drops pointer test and channel enables
// - Predicate from flag bits, combine select, invert
// - Quad-aligned swizzle reorders within groups of four
// - Source to execution, execution to destination conversion
// - Source modifier after conversion, before the operation
// - Float saturation clamps into zero to one
// - Integer saturation clamps to destination type range
// - Accumulator copy only when instruction requests it
// - Accumulator disable bit blocks every execution copy to the accumulator; bus writes still land
// - Condition bits written into the chosen flag register
// - Flush mode cleans inf, denorm and NaN
// - Upper eight-channel groups land in following registers
// - Up to thirty-two logical channels per instruction
// - Send with thread end flag ends the thread
// - Enabled exception jumps to system routine, else not
// - Single program flow runs all channels together
module scm_channel_exec import scm_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [3:0] avByteEnable,
  input wire logic [DATA_W-1:0] avWriteData,
  output logic [DATA_W-1:0] avReadData,
  output logic avWaitRequest,
  input wire logic instValid,
  input scm_inst_t inst,
  output logic instReady,
  output logic instDone,
  output logic threadEnded,
  output logic sysRoutineReq
);
  scm_state_t stateQ; // Sequencer state
  scm_inst_t instQ; // Instruction being executed
  logic [CH_W-1:0] chanQ; // Channel handled this cycle
  logic [CTRL_W-1:0] ctrlQ; // control_register_zero
  logic [CHANNELS-1:0] flagAQ; // flag_subregister_a
  logic [CHANNELS-1:0] flagBQ; // Second flag subregister
  logic [DATA_W-1:0] srcFileQ [CHANNELS]; // Source operand elements
  logic [DATA_W-1:0] dstFileQ [2**DST_IDX_W]; // Destination registers
  logic [DATA_W-1:0] accFileQ [CHANNELS]; // Accumulator elements
  logic [IP_W-1:0] pcipQ [CHANNELS]; // per_channel_instruction_pointer
  logic endedQ; // Thread has terminated
  logic excQ; // Exception taken, sticky
  logic ackQ; // Bus answer cycle
  logic [DATA_W-1:0] readDataQ;
  logic doneQ;
  logic sysReqQ;

  logic [CHANNELS-1:0] predFlags; // Flag register feeding the predicate
  logic [CHANNELS-1:0] predMask;
  logic [CHANNELS-1:0] chanEnable; // Combined mask
  logic accept;
  logic illegal;
  logic lastChan;
  logic chanWe;
  logic accWe;
  logic flagWe;
  logic [CNT_W-1:0] countM1;
  logic [CH_W-1:0] srcIdx;
  logic [DST_IDX_W-1:0] dstIdx;
  scm_elem_in_t elemIn;
  scm_elem_out_t elemOut;
  logic busReq;
  logic busWr;
  logic [3:0] region;
  logic [5:0] wordIdx;
  logic [DATA_W-1:0] byteMask;
  logic [DATA_W-1:0] rdMux;

  // Byte enables widened to a bit mask
  assign byteMask = {{8{avByteEnable[3]}}, {8{avByteEnable[2]}},
    {8{avByteEnable[1]}}, {8{avByteEnable[0]}}};

  // Merge bus write data into an old word under the byte enables
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] oldVal);
    merge = (oldVal & ~byteMask) | (avWriteData & byteMask);
  endfunction

  // Avalon slave: one wait cycle, then the answer
  assign busReq = avRead | avWrite;
  assign avWaitRequest = busReq & ~ackQ;
  assign busWr = avWrite & ackQ; // Writes land on the released edge
  assign region = avAddress[ADDR_W-1:REGION_LSB];
  assign wordIdx = avAddress[REGION_LSB-1:WORD_LSB];
  assign avReadData = readDataQ;

  // Answer strobe toggles after each request cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ackQ <= 1'b0;
    else ackQ <= busReq & ~ackQ;
  end

  // Read mux; unmapped words and upper windows read as zero
  always_comb begin
    rdMux = '0;
    case (region)
      R_CSR: begin
        case (wordIdx)
          W_CTRL: rdMux = DATA_W'(ctrlQ);
          W_STATUS: rdMux = DATA_W'({excQ, endedQ, stateQ == ST_RUN});
          W_FLAG_A: rdMux = flagAQ;
          W_FLAG_B: rdMux = flagBQ;
          default: rdMux = '0;
        endcase
      end
      R_SRC: if (!wordIdx[CH_W]) rdMux = srcFileQ[wordIdx[CH_W-1:0]];
      R_DST: rdMux = dstFileQ[wordIdx];
      R_ACC: if (!wordIdx[CH_W]) rdMux = accFileQ[wordIdx[CH_W-1:0]];
      R_PER_CHANNEL_INSTRUCTION_POINTER: if (!wordIdx[CH_W]) rdMux = DATA_W'(pcipQ[wordIdx[CH_W-1:0]]);
      default: rdMux = '0;
    endcase
  end

  // Read data is captured in the wait cycle and stands at the answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) readDataQ <= '0;
    else if (avRead && !ackQ) readDataQ <= rdMux;
  end

  // Control register zero, byte lane zero only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctrlQ <= CTRL_RESET;
    else if (busWr && region == R_CSR && wordIdx == W_CTRL && avByteEnable[0])
      ctrlQ <= avWriteData[CTRL_W-1:0];
  end

  // Source elements and per-channel pointers, written by software only
  always_ff @(posedge clk) begin
    if (busWr && region == R_SRC && !wordIdx[CH_W])
      srcFileQ[wordIdx[CH_W-1:0]] <= merge(srcFileQ[wordIdx[CH_W-1:0]]);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < CHANNELS; k++) pcipQ[k] <= '0;
    end else if (busWr && region == R_PER_CHANNEL_INSTRUCTION_POINTER && !wordIdx[CH_W]) begin
      pcipQ[wordIdx[CH_W-1:0]] <= avWriteData[IP_W-1:0];
    end
  end

  // Handshake with the decoder; an ended thread takes nothing more
  assign instReady = (stateQ == ST_IDLE) && !endedQ;
  assign accept = instValid & instReady;
  // Counts of zero or beyond thirty-two are illegal
  assign illegal = (inst.channelCount == '0) ||
    (inst.channelCount > MAX_COUNT);
  assign countM1 = instQ.channelCount - ONE_COUNT;
  assign lastChan = (CNT_W'(chanQ) == countM1);

  // Sequencer: one logical channel per cycle on one element unit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= ST_IDLE;
    end else begin
      case (stateQ)
        ST_IDLE: if (accept && !illegal) stateQ <= ST_RUN;
        ST_RUN: if (lastChan) stateQ <= ST_IDLE;
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  // Instruction latch and channel counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instQ <= '0;
      chanQ <= '0;
    end else if (accept) begin
      instQ <= inst;
      chanQ <= '0;
    end else if (stateQ == ST_RUN) begin
      chanQ <= chanQ + 1'b1;
    end
  end

  // Predicate source register
  assign predFlags = instQ.flagSel ? flagBQ : flagAQ;

  // Per-channel mask build
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    logic [QUAD-1:0] quadFlags; // Flags of this channel's group of four
    logic predRaw;
    logic ipOk;
    logic enOk;
    assign quadFlags = predFlags[(i/QUAD)*QUAD +: QUAD];
    // Boolean combine chosen per instruction
    assign predRaw =
      (instQ.predicateCombineSelect == PC_PER_CHANNEL) ? predFlags[i] :
      (instQ.predicateCombineSelect == PC_ANY_QUAD) ? |quadFlags :
      &quadFlags;
    assign predMask[i] = (instQ.predicateCombineSelect == PC_NONE) ? 1'b1 :
      predRaw ^ instQ.predicateInvert;
    // Pointer test skipped under single program flow or ignore masks
    assign ipOk = ctrlQ[CTRL_SPF] | instQ.ignoreMasks |
      (pcipQ[i] == instQ.ip);
    assign enOk = !instQ.quadAlignedAccess | instQ.ignoreMasks |
      instQ.destChannelWriteEnable[i%QUAD];
    assign chanEnable[i] = (CNT_W'(i) < instQ.channelCount) &
      instQ.executionChannelMask[i] & predMask[i] & ipOk & enOk;
  end

  // Swizzle picks the source element within the group of four
  assign srcIdx = instQ.quadAlignedAccess ?
    {chanQ[CH_W-1:2], instQ.swizzle[chanQ[1:0]]} : chanQ;
  // Channel groups of eight step to consecutive registers
  assign dstIdx = {instQ.dstReg + DREG_W'(chanQ[CH_W-1:3]),
    chanQ[2:0]};

  // Element unit inputs for the current channel
  always_comb begin
    elemIn.data = srcFileQ[srcIdx];
    elemIn.srcType = instQ.srcType;
    elemIn.dstType = instQ.dstType;
    elemIn.srcMod = instQ.srcMod;
    elemIn.saturate = instQ.saturate;
    elemIn.flushMode = ctrlQ[CTRL_FLUSH];
    elemIn.condMod = instQ.conditionModifier;
  end

  scm_elem_unit u_elem (
    .elemIn(elemIn),
    .elemOut(elemOut)
  );

  // Write strobes; disabled channels write nothing
  assign chanWe = (stateQ == ST_RUN) && chanEnable[chanQ];
  assign accWe = chanWe && instQ.accumulatorWriteSelect &&
    !ctrlQ[CTRL_ACC_DIS];
  assign flagWe = chanWe && (instQ.conditionModifier != CM_NONE);

  // Destination file: execution wins over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (busWr && region == R_DST)
      dstFileQ[wordIdx] <= merge(dstFileQ[wordIdx]);
    if (chanWe) dstFileQ[dstIdx] <= elemOut.result;
  end

  // Accumulator copy as a side effect
  always_ff @(posedge clk) begin
    if (busWr && region == R_ACC && !wordIdx[CH_W])
      accFileQ[wordIdx[CH_W-1:0]] <= merge(accFileQ[wordIdx[CH_W-1:0]]);
    if (accWe) accFileQ[chanQ] <= elemOut.result;
  end

  // Flag subregisters: the hardware bit beats a same-cycle bus write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flagAQ <= '0;
      flagBQ <= '0;
    end else begin
      if (busWr && region == R_CSR && wordIdx == W_FLAG_A)
        flagAQ <= merge(flagAQ);
      if (busWr && region == R_CSR && wordIdx == W_FLAG_B)
        flagBQ <= merge(flagBQ);
      if (flagWe && instQ.flagSel) flagBQ[chanQ] <= elemOut.condBit;
      if (flagWe && !instQ.flagSel)
        flagAQ[chanQ] <= elemOut.condBit;
    end
  end

  // Done pulse, thread end and system routine request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      doneQ <= 1'b0;
      sysReqQ <= 1'b0;
    end else begin
      doneQ <= (stateQ == ST_RUN) && lastChan;
      sysReqQ <= accept && illegal && ctrlQ[CTRL_EXC_EN];
    end
  end

  // Sticky status; write one clears, a new event wins the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      endedQ <= 1'b0;
      excQ <= 1'b0;
    end else begin
      if (busWr && region == R_CSR && wordIdx == W_STATUS &&
          avByteEnable[0]) begin
        if (avWriteData[ST_ENDED]) endedQ <= 1'b0;
        if (avWriteData[ST_EXC]) excQ <= 1'b0;
      end
      if (stateQ == ST_RUN && lastChan && instQ.isSend &&
          instQ.threadEndFlag)
        endedQ <= 1'b1;
      if (accept && illegal && ctrlQ[CTRL_EXC_EN]) excQ <= 1'b1;
    end
  end

  assign instDone = doneQ;
  assign threadEnded = endedQ;
  assign sysRoutineReq = sysReqQ;

  // Checks
  logic [CHANNELS:0] oneShl; // Helper: independent range mask
  logic [CHANNELS:0] rangeWide;
  logic [CHANNELS-1:0] rangeChk;
  assign oneShl = {{CHANNELS{1'b0}}, 1'b1} << instQ.channelCount;
  assign rangeWide = oneShl - {{CHANNELS{1'b0}}, 1'b1};
  assign rangeChk = rangeWide[CHANNELS-1:0];
  // Helper: channel of the previous cycle, for the accumulator check
  logic [CH_W-1:0] accIdxQ;
  always_ff @(posedge clk) accIdxQ <= chanQ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sEndingSend;
    stateQ == ST_RUN && lastChan && instQ.isSend && instQ.threadEndFlag;
  endsequence
  sequence sLegalTaken;
    accept && !illegal;
  endsequence
  sequence sBadTaken;
    accept && illegal;
  endsequence

  AST_RANGE: assert property ((chanEnable & ~rangeChk) == '0)
    else $error("channel enabled beyond channel count");
  AST_EXECUTION_CHANNEL_MASK: assert property (
    (chanEnable & ~instQ.executionChannelMask) == '0)
    else $error("channel enabled against execution mask");
  AST_IGNORE: assert property (instQ.ignoreMasks |-> chanEnable ==
    (rangeChk & instQ.executionChannelMask & predMask))
    else $error("ignore masks did not bypass pointer and enables");
  AST_SPF: assert property (ctrlQ[CTRL_SPF] &&
    !instQ.quadAlignedAccess
    |-> chanEnable == (rangeChk & instQ.executionChannelMask & predMask))
    else $error("single program flow still tested pointers");
  AST_SWIZZLE: assert property (stateQ == ST_RUN |->
    srcIdx[CH_W-1:2] == chanQ[CH_W-1:2] && (instQ.quadAlignedAccess ||
    srcIdx[1:0] == chanQ[1:0]))
    else $error("swizzle left its group or acted outside quad mode");
  AST_ACC_DIS: assert property (ctrlQ[CTRL_ACC_DIS] &&
    stateQ == ST_RUN
    |=> accFileQ[accIdxQ] == $past(accFileQ[chanQ]) || $past(busWr))
    else $error("accumulator changed while disabled");
  AST_SKIP: assert property (stateQ == ST_RUN && !chanEnable[chanQ] &&
    !busWr |=> $stable(flagAQ) && $stable(flagBQ))
    else $error("disabled channel touched the flags");
  AST_THREAD_END: assert property (sEndingSend |=>
    threadEnded && !instReady)
    else $error("thread end flag did not end the thread");
  AST_EXC: assert property (sBadTaken |=>
    sysRoutineReq == $past(ctrlQ[CTRL_EXC_EN]) && stateQ == ST_IDLE)
    else $error("system routine request does not follow enable");
  AST_RUN_LEN: assert property (sLegalTaken |=>
    stateQ == ST_RUN ##[1:32] instDone)
    else $error("instruction did not finish within thirty-two channels");
  AST_FSAT: assert property (stateQ == ST_RUN && instQ.saturate &&
    instQ.srcType == TY_F |-> elemOut.result <= F_ONE)
    else $error("float saturation outside zero to one");
  AST_FLUSH: assert property (stateQ == ST_RUN &&
    ctrlQ[CTRL_FLUSH] && instQ.srcType == TY_F
    |-> elemOut.result[30:23] != F_EXP_ONES)
    else $error("flush mode produced inf or NaN");
endmodule

/* File: dv/scm_dispatch_model.sv */
`timescale 1ns/1ps
// Decoder and dispatcher stand-in: offers one instruction at a time
module scm_dispatch_model import scm_pkg::*; (
  input wire logic clk,
  output logic instValid,
  output scm_inst_t inst,
  input wire logic instReady
);
  initial begin
    instValid = 1'h0;
    inst = '0;
  end
  // Hold the offer until the rising edge that sees ready high
  task automatic issue(input scm_inst_t x);
    @(posedge clk);
    instValid <= 1'h1;
    inst <= x;
    forever begin
      @(posedge clk);
      if (instReady) break;
    end
    instValid <= 1'h0;
    // Idle bus shows junk, so a design using stale fields is caught
    inst <= ~x;
  endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb import scm_pkg::*;;
  typedef struct packed {
    scm_type_t st;
    scm_type_t dt;
    scm_mod_t md;
    logic sat;
    logic fl;
    logic [31:0] s;
    logic [31:0] e;
  } scm_row_t;
  logic clk, rst_b, avRead, avWrite, avWaitRequest, instValid, instReady;
  logic instDone, threadEnded, sysRoutineReq;
  logic [11:0] avAddress;
  logic [3:0] avByteEnable;
  logic [31:0] avWriteData, avReadData, q, x;
  scm_inst_t inst, b, base;
  scm_row_t rows [10];
  int nErrors, nTests, nSys, cyc;
  scm_channel_exec i_scm_channel_exec (.clk(clk), .rst_b(rst_b),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avByteEnable(avByteEnable), .avWriteData(avWriteData),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .instValid(instValid), .inst(inst), .instReady(instReady),
    .instDone(instDone), .threadEnded(threadEnded),
    .sysRoutineReq(sysRoutineReq));
  scm_dispatch_model i_scm_dispatch_model (.clk(clk),
    .instValid(instValid), .inst(inst), .instReady(instReady));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Exception transfers counted; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sysRoutineReq === 1'h1) nSys++;
    if (cyc == 8000) begin
      nErrors++;
      close_out();
    end
  end
  task automatic close_out;
    if (nErrors == 0 && nTests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    nTests++;
    if (s !== e) begin
      nErrors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // One Avalon transfer held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avAddress <= a;
    avWriteData <= d;
    avRead <= !w;
    avWrite <= w;
    forever begin
      @(posedge clk);
      if (!avWaitRequest) break;
    end
    r = avReadData;
    avRead <= 1'h0;
    avWrite <= 1'h0;
  endtask
  task automatic run(input scm_inst_t x);
    i_scm_dispatch_model.issue(x);
    @(posedge clk iff instDone === 1'h1);
  endtask
  initial begin
    {rst_b, avRead, avWrite, avAddress, avWriteData} = '0;
    avByteEnable = 4'hF;
    base = '0;
    base.channelCount = 6'h01;
    base.executionChannelMask = '1;
    base.destChannelWriteEnable = 4'hF;
    base.swizzle = 8'hE4;
    // Element cases: type, modifier, saturate, flush, in, out
    rows = '{'{TY_UD, TY_UD, MOD_NONE, 1'h0, 1'h0, 32'h5, 32'h5},
      '{TY_F, TY_F, MOD_NEG, 1'h0, 1'h0, 32'h3F80_0000, 32'hBF80_0000},
      '{TY_F, TY_F, MOD_ABS, 1'h0, 1'h0, 32'hBF80_0000, 32'h3F80_0000},
      '{TY_F, TY_F, MOD_NEG_ABS, 1'h0, 1'h0, 32'h3F80_0000, 32'hBF80_0000},
      '{TY_F, TY_F, MOD_NONE, 1'h1, 1'h0, 32'h4000_0000, 32'h3F80_0000},
      '{TY_F, TY_F, MOD_NONE, 1'h1, 1'h0, 32'hBF80_0000, 32'h0},
      '{TY_D, TY_UW, MOD_NONE, 1'h1, 1'h0, 32'h0001_0000, 32'hFFFF},
      '{TY_F, TY_F, MOD_NONE, 1'h0, 1'h1, 32'h7F80_0000, 32'h7F7F_FFFF},
      '{TY_F, TY_F, MOD_NONE, 1'h0, 1'h1, 32'hFFC0_0000, 32'h0},
      '{TY_D, TY_W, MOD_NONE, 1'h1, 1'h0, 32'hFFFF_0000, 32'hFFFF_8000}};
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    bus(1'h0, 12'h000, 32'h0, q);
    chk("ctrl", 32'h0, q);
    foreach (rows[i]) begin
      bus(1'h1, 12'h000, {29'h0, rows[i].fl, 2'h0}, q);
      bus(1'h1, 12'h100, rows[i].s, q);
      b = base;
      b.srcType = rows[i].st;
      b.dstType = rows[i].dt;
      b.srcMod = rows[i].md;
      b.saturate = rows[i].sat;
      b.conditionModifier = CM_NOT_ZERO;
      run(b);
      bus(1'h0, 12'h200, 32'h0, q);
      chk("dst", rows[i].e, q);
      bus(1'h0, 12'h008, 32'h0, q);
      chk("flag", {31'h0, rows[i].e != 0}, q);
    end
    // Full width, reversed swizzle, four result registers
    for (int n = 0; n < 32; n++) bus(1'h1, 12'h100 + 12'(4 * n), 32'(n), q);
    b = base;
    {b.channelCount, b.quadAlignedAccess, b.swizzle} = {6'h20, 1'h1, 8'h1B};
    b.dstReg = 3'h4;
    run(b);
    for (int n = 0; n < 32; n++) begin
      bus(1'h0, 12'h280 + 12'(4 * n), 32'h0, q);
      chk("swz", 32'(n ^ 3), q);
    end
    // Predicate modes, invert, quad enables, count limit
    bus(1'h1, 12'h008, 32'h0000_00FE, q);
    for (int p = 0; p < 3; p++) begin
      b = base;
      {b.channelCount, b.dstReg} = {6'h08, 3'h4};
      b.executionChannelMask = p == 2 ? 32'h2 : 32'hF5;
      b.predicateCombineSelect = p == 0 ? PC_ALL_QUAD
        : p == 1 ? PC_PER_CHANNEL : PC_ANY_QUAD;
      {b.predicateInvert, b.quadAlignedAccess} = {p == 0, p == 1};
      b.destChannelWriteEnable = p == 1 ? 4'hD : 4'hF;
      run(b);
    end
    for (int n = 0; n < 16; n++) begin
      bus(1'h0, 12'h280 + 12'(4 * n), 32'h0, q);
      x = n < 8 && 8'hD7 >> n & 1 ? 32'(n) : 32'(n ^ 3);
      chk("mask", x, q);
    end
    // Accumulator disable, single flow, ignore masks, pointer mismatch
    for (int k = 0; k < 4; k++) begin
      bus(1'h1, 12'h300, 32'hA5A5_0000, q);
      bus(1'h1, 12'h000, k == 0 ? 32'h1 : k == 1 ? 32'h2 : 32'h0, q);
      b = base;
      {b.accumulatorWriteSelect, b.ignoreMasks} = {1'h1, k == 2};
      b.ip = k == 0 ? 12'h0 : 12'h5;
      run(b);
      bus(1'h0, 12'h300, 32'h0, q);
      x = k == 1 || k == 2 ? 32'h0 : 32'hA5A5_0000;
      chk("acc", x, q);
    end
    // Illegal count with exception enabled, then disabled
    for (int e = 1; e >= 0; e--) begin
      bus(1'h1, 12'h000, 32'(e * 8), q);
      b = base;
      b.channelCount = 6'h00;
      i_scm_dispatch_model.issue(b);
      repeat (3) @(posedge clk);
      chk("sys", 32'h1, 32'(nSys));
    end
    b = base;
    {b.isSend, b.threadEndFlag} = 2'h3;
    run(b);
    @(negedge clk);
    chk("end", 32'h2, {30'h0, threadEnded, instReady});
    // Reset while idle frees the ended thread and clears the flags
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    bus(1'h0, 12'h008, 32'h0, q);
    chk("rst", 32'h1, {30'h0, threadEnded, instReady});
    chk("rstflag", 32'h0, q);
    close_out();
  end
endmodule
